/* File: asrc_defs.vh */
`ifndef ASRC_DEFS_VH
`define ASRC_DEFS_VH

// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define ASRC_ADDR_W 19
`define ASRC_DATA_W 8

// ---------------------------------------------------------------
// Timing, slowest grade, in ns and ms
// ---------------------------------------------------------------
`define ASRC_CLK_NS 25
`define ASRC_T_ACC_NS 100
`define ASRC_T_GATE_NS 50
`define ASRC_T_WP_NS 80
`define ASRC_T_DSU_NS 35
`define ASRC_T_DIS_NS 35
`define ASRC_T_REC_MS 5
// Least times round up to whole cycles.
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_ACC_CYC `ASRC_CYC_UP(`ASRC_T_ACC_NS)
`define ASRC_WP_CYC `ASRC_CYC_UP(`ASRC_T_WP_NS)
`define ASRC_DIS_CYC `ASRC_CYC_UP(`ASRC_T_DIS_NS)
`define ASRC_REC_CYC ((`ASRC_T_REC_MS * 1000000 + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)

`endif

/* File: asrc_wait_timer.v */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Down-counter: load a count, done pulses high when it reaches one.
// ---------------------------------------------------------------
module asrc_wait_timer #(
  parameter CNT_W = 18
) (
  input wire core_clk,
  input wire sys_rst,
  input wire load,
  input wire [CNT_W-1:0] load_val,
  output wire busy,
  output wire done
);
  reg [CNT_W-1:0] cnt_q;

  // Counting stops at zero so an idle timer draws no toggles.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= {CNT_W{1'b0}};
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != {CNT_W{1'b0}}) begin
      cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (cnt_q != {CNT_W{1'b0}});
  assign done = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule // asrc_wait_timer
`default_nettype wire

/* File: asrc_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defs.vh"
// ---------------------------------------------------------------
// Host controller for the 512K x 8 asynchronous static memory.
// One request at a time: req_valid with req_write, req_addr and
// req_wdata; answered by a one-cycle done pulse with read data.
// Reset counts as a supply return, so the first access waits out the recovery time.
// ---------------------------------------------------------------
module asrc_host #(
  parameter ADDR_W = `ASRC_ADDR_W,
  parameter DATA_W = `ASRC_DATA_W,
  parameter ACC_CYC = `ASRC_ACC_CYC,
  parameter WP_CYC = `ASRC_WP_CYC,
  parameter DIS_CYC = `ASRC_DIS_CYC,
  parameter REC_CYC = `ASRC_REC_CYC
) (
  input wire core_clk,
  input wire sys_rst,
  input wire req_valid,
  input wire req_write,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  input wire power_down,
  output reg req_ready,
  output reg resp_done,
  output reg [DATA_W-1:0] resp_rdata,
  output reg [ADDR_W-1:0] mem_addr,
  output reg chip_enable_low,
  output reg store_strobe,
  output reg drive_gate,
  input wire [DATA_W-1:0] io_bus_in,
  output reg [DATA_W-1:0] io_bus_out,
  output reg io_bus_oe_n
);
  localparam CNT_W = 18;
  localparam [2:0] ST_RECOVER = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RD = 3'h2;
  localparam [2:0] ST_WR = 3'h3;
  localparam [2:0] ST_TURN = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg tmr_load;
  reg [CNT_W-1:0] tmr_val;
  wire tmr_busy;
  wire tmr_done;
  wire take_wr;
  wire take_rd;
  wire wr_end;
  wire rd_end;
  wire turn_end;
  wire asleep;

  // Width-safe conversion of a cycle count to the timer load.
  function [CNT_W-1:0] cyc;
    input integer n;
    begin
      cyc = n[CNT_W-1:0];
    end
  endfunction

  asrc_wait_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ---------------------------------------------------------------
  // Step decodes
  // ---------------------------------------------------------------
  // A request is taken on the edge that leaves idle; the pins move on
  // that same edge, so the device sees address and controls together.
  assign take_wr = (state_q == ST_IDLE) && (state_d == ST_WR);
  assign take_rd = (state_q == ST_IDLE) && (state_d == ST_RD);
  // Each access ends on the timer's last count, never on a free edge.
  assign wr_end = (state_q == ST_WR) && tmr_done;
  assign rd_end = (state_q == ST_RD) && tmr_done;
  assign turn_end = (state_q == ST_TURN) && tmr_done;
  // Sleep and recovery hold the memory deselected throughout.
  assign asleep = (state_q == ST_SLEEP) || (state_q == ST_RECOVER);

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  // Cycle plan, counted from the take edge c0 at 25 ns a cycle:
  //   read:  c0 enable and gate fall; c4 data taken, both rise;
  //          c6 idle again, so the device has let go of the bus.
  //   write: c0 enable, strobe and host drive start; c4 strobe rises
  //          and the byte is stored; c5 enable and host drive end.
  // A faster part only wastes cycles; counts follow the slowest grade
  // so that any fitted part is served.
  // Next state and timer loads; every wait is a timer expiry.
  always @* begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_val = {CNT_W{1'b0}};
    case (state_q)
      ST_RECOVER: begin
        if (!tmr_busy) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (power_down) begin
          state_d = ST_SLEEP;
        end else if (req_valid) begin
          tmr_load = 1'b1;
          if (req_write) begin
            state_d = ST_WR;
            tmr_val = cyc(WP_CYC);
          end else begin
            state_d = ST_RD;
            tmr_val = cyc(ACC_CYC);
          end
        end
      end
      ST_RD: begin
        if (tmr_done) begin
          state_d = ST_TURN;
          tmr_load = 1'b1;
          tmr_val = cyc(DIS_CYC);
        end
      end
      ST_WR: begin
        if (tmr_done) begin
          state_d = ST_TURN;
          tmr_load = 1'b1;
          tmr_val = cyc(1);
        end
      end
      ST_TURN: begin
        if (tmr_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!power_down) begin
          state_d = ST_RECOVER;
          tmr_load = 1'b1;
          tmr_val = cyc(REC_CYC);
        end
      end
      default: begin
        state_d = ST_RECOVER;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // All pins are registered; address and data stay put for the whole
  // access so the strobe edge never races them.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      mem_addr <= {ADDR_W{1'b0}};
      chip_enable_low <= 1'b1;
      store_strobe <= 1'b1;
      drive_gate <= 1'b1;
      io_bus_out <= {DATA_W{1'b0}};
      io_bus_oe_n <= 1'b1;
      req_ready <= 1'b0;
      resp_done <= 1'b0;
      resp_rdata <= {DATA_W{1'b0}};
    end else begin
      resp_done <= 1'b0;
      req_ready <= (state_d == ST_IDLE) && !power_down;
      if (take_wr) begin
        // Strobe falls together with enable while gate stays high, so the device never drives.
        mem_addr <= req_addr;
        io_bus_out <= req_wdata;
        io_bus_oe_n <= 1'b0;
        drive_gate <= 1'b1;
        chip_enable_low <= 1'b0;
        store_strobe <= 1'b0;
      end else if (take_rd) begin
        mem_addr <= req_addr;
        io_bus_oe_n <= 1'b1;
        chip_enable_low <= 1'b0;
        store_strobe <= 1'b1;
        drive_gate <= 1'b0;
      end else if (wr_end) begin
        // Strobe rises first and ends the overlap; data held one more cycle.
        store_strobe <= 1'b1;
      end else if (rd_end) begin
        // Data is taken on the edge that also lifts enable, after a full access time.
        resp_rdata <= io_bus_in;
        resp_done <= 1'b1;
        chip_enable_low <= 1'b1;
        drive_gate <= 1'b1;
      end else if (turn_end) begin
        // Only a write answers here; a read has already answered.
        chip_enable_low <= 1'b1;
        io_bus_oe_n <= 1'b1;
        if (store_strobe && !io_bus_oe_n) begin
          resp_done <= 1'b1;
        end
      end else if (asleep) begin
        chip_enable_low <= 1'b1;
        store_strobe <= 1'b1;
        drive_gate <= 1'b1;
        io_bus_oe_n <= 1'b1;
      end
    end
  end
endmodule // asrc_host
`default_nettype wire

/* File: asrc_sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// --
// Byte-wide static memory model, no clock.
// --
module asrc_sram_model #(parameter T_ACC = 55) (
  input wire logic [18:0] addr,
  input wire logic cel,
  input wire logic ss,
  input wire logic gate,
  input wire logic [7:0] host_d,
  input wire logic host_oe_n,
  output logic [7:0] bus
);
  logic [7:0] mem [0:524287];
  logic rd_on;
  logic [18:0] rd_addr;
  // Drive late, so a hasty sample sees wrong data; gate and enable share the delay.
  assign #(T_ACC) rd_on = !cel && ss && !gate;
  // Old data lingers briefly after the address moves.
  assign #(10) rd_addr = addr;
  // A floating bus shows the inverse, never a kind default.
  assign bus = !host_oe_n ? host_d : rd_on ? mem[rd_addr] : ~mem[rd_addr];
  // Store when the first of the two strobes rises.
  always @(posedge (cel | ss)) mem[addr] <= bus;
endmodule // asrc_sram_model
`default_nettype wire

/* File: asrc_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// --
// Pin checks of the host controller.
// --
module asrc_host_assertions #(parameter REC_CYC = 20) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_down,
  input wire logic req_ready,
  input wire logic resp_done,
  input wire logic [18:0] mem_addr,
  input wire logic chip_enable_low,
  input wire logic store_strobe,
  input wire logic drive_gate,
  input wire logic io_bus_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] up_q;
  // Cycles awake; reset counts as a supply return.
  always @(posedge core_clk) begin
    if (sys_rst || power_down) up_q <= 32'h0;
    else up_q <= up_q + 32'h1;
  end
  property p_fight; !drive_gate |-> io_bus_oe_n && store_strobe; endproperty
  a_fight: assert property (p_fight) else $error("bus fight");
  property p_wgate; !store_strobe |-> drive_gate && !chip_enable_low; endproperty
  a_wgate: assert property (p_wgate) else $error("gate in write");
  property p_addr; !chip_enable_low && !$past(chip_enable_low) |-> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_wp; $fell(store_strobe) |-> (!store_strobe)[*4] ##1 store_strobe; endproperty
  a_wp: assert property (p_wp) else $error("strobe width");
  property p_ce; $rose(store_strobe) |-> !chip_enable_low && !$past(chip_enable_low, 4); endproperty
  a_ce: assert property (p_ce) else $error("enable setup");
  property p_rd; $fell(drive_gate) |-> !chip_enable_low ##4 resp_done; endproperty
  a_rd: assert property (p_rd) else $error("read answer");
  property p_wd; $fell(store_strobe) |-> ##5 resp_done && chip_enable_low; endproperty
  a_wd: assert property (p_wd) else $error("write answer");
  property p_pd; power_down && chip_enable_low |=> chip_enable_low; endproperty
  a_pd: assert property (p_pd) else $error("access asleep");
  property p_rec; req_ready |-> up_q + 32'h1 >= REC_CYC; endproperty
  a_rec: assert property (p_rec) else $error("early ready");
  c_rd: cover property ($fell(drive_gate));
  c_wr: cover property ($fell(store_strobe));
  c_rec: cover property ($fell(power_down));
endmodule // asrc_host_assertions
bind asrc_host asrc_host_assertions #(.REC_CYC(REC_CYC)) u_chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .power_down(power_down), .req_ready(req_ready), .resp_done(resp_done),
  .mem_addr(mem_addr), .chip_enable_low(chip_enable_low), .store_strobe(store_strobe),
  .drive_gate(drive_gate), .io_bus_oe_n(io_bus_oe_n));
`default_nettype wire

/* File: asrc_host_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defs.vh"
module asrc_host_bench;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic power_down = 1'h0;
  logic [18:0] req_addr = 19'h0;
  logic [7:0] req_wdata = 8'h0;
  wire req_ready, resp_done, cel, ss, gate, oe_n;
  wire [7:0] rdata, bus, dout;
  wire [18:0] maddr;
  int n_errors = 0;
  int check_count = 0;
  logic [18:0] ta [4] = '{19'h0, 19'h7FFFF, 19'h12345, 19'h40000};
  logic [7:0] td [4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
  // 40 MHz clock.
  always #12.5 core_clk = ~core_clk;
  asrc_host #(.REC_CYC(20)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .power_down(power_down), .req_ready(req_ready),
    .resp_done(resp_done), .resp_rdata(rdata), .mem_addr(maddr),
    .chip_enable_low(cel), .store_strobe(ss), .drive_gate(gate),
    .io_bus_in(bus), .io_bus_out(dout), .io_bus_oe_n(oe_n));
  // The part answers just inside the slowest access time, so an early sample fails.
  asrc_sram_model #(.T_ACC(`ASRC_T_ACC_NS - 10)) u_mem (.addr(maddr), .cel(cel), .ss(ss),
    .gate(gate),
    .host_d(dout), .host_oe_n(oe_n), .bus(bus));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One access; waits for ready, then times the answer.
  task xfer(input logic w, input logic [18:0] a, input logic [7:0] d);
    int k;
    for (k = 0; k < 300 && req_ready !== 1'b1; k++) @(negedge core_clk);
    chk("ready", 1, req_ready);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req_valid = 1'b0;
    for (k = 0; k < 20 && resp_done !== 1'b1; k++) @(negedge core_clk);
    chk("latency", w ? (`ASRC_WP_CYC + 1) : `ASRC_ACC_CYC, k);
  endtask
  task sc_rw;
    for (int i = 0; i < 4; i++) xfer(1'b1, ta[i], td[i]);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, ta[i], 8'h0);
      chk("rdata", td[i], rdata);
    end
    $display("read write test over");
  endtask
  // Sleep refuses work and needs the full recovery.
  task sc_sleep;
    int k;
    power_down = 1'b1;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = 19'h0;
    req_wdata = 8'h11;
    for (k = 0; k < 6; k++) begin
      @(negedge core_clk);
      chk("enable", 1, cel);
    end
    req_valid = 1'b0;
    power_down = 1'b0;
    for (k = 0; k < 300 && req_ready !== 1'b1; k++) @(negedge core_clk);
    chk("recovery", 1, k >= 20);
    xfer(1'b0, 19'h0, 8'h0);
    chk("kept", 8'hA5, rdata);
    $display("sleep test over");
  endtask
  // Hang guard.
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  // Reset for 2 cycles, then the scenarios.
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    sc_rw;
    sc_sleep;
    end_sim;
  end
endmodule // asrc_host_bench
`default_nettype wire
